/* File: hw/flash_prog_pkg.sv */
/*
  shared constants for the flash self-programming controller: register map,
  field positions, reset values, geometry and operation timing.
  assumes a 50 MHz mclk and an AXI4-Lite register bus with 32-bit data.
*/
package flash_prog_pkg;

  // register byte addresses on the AXI4-Lite slave
  localparam logic [7:0] OFF_CONTROL = 8'h00;
  localparam logic [7:0] OFF_ADDR_LOW = 8'h04;
  localparam logic [7:0] OFF_ADDR_HIGH = 8'h08;
  localparam logic [7:0] OFF_UNLOCK_KEY = 8'h0C;
  localparam logic [7:0] OFF_TABLE_PAGE = 8'h10;
  localparam logic [7:0] OFF_STATUS = 8'h14;

  // flash_control fields
  localparam int CTL_START_BIT = 15;
  localparam int CTL_WRITE_EN_BIT = 14;
  localparam int CTL_WRITE_ERR_BIT = 13;
  localparam int CTL_OP_LSB = 0;
  localparam int CTL_OP_W = 7;
  localparam logic [15:0] CTL_RESET = 16'h0000;
  localparam logic [6:0] OP_ROW_ERASE = 7'h41;
  localparam logic [6:0] OP_ROW_PROGRAM = 7'h01;

  // status register fields
  localparam int STAT_DONE_BIT = 0;
  localparam int STAT_BUSY_BIT = 1;

  // unlock keys
  localparam logic [7:0] KEY_FIRST = 8'h55;
  localparam logic [7:0] KEY_SECOND = 8'hAA;

  // geometry: 32 words a row, 128 rows a panel, 24-bit words
  localparam int ROW_WORDS = 32;
  localparam int ROWS_PER_PANEL = 128;
  localparam int ROW_BYTES = 96;
  localparam int WORD_W = 24;

  // table write cost in cycles, and operation time
  localparam int TABLE_WRITE_CYCLES = 2;
  localparam int OP_TIME_US = 2000;
  localparam int CLK_MHZ = 50;
  localparam int OP_CYCLES = OP_TIME_US * CLK_MHZ;

  typedef enum logic [1:0] {
    ST_IDLE,
    ST_ERASE,
    ST_PROGRAM,
    ST_FINISH
  } seq_state_t;

endpackage

/* File: hw/flash_self_program_ctrl.sv */
/*
  flash_self_program_ctrl: run-time self-programming sequencer.
  holds table page and flash address registers, 32-word row write latches,
  the unlock sequence, row erase/program with processor stall, and the
  control/status registers on an AXI4-Lite slave.
  assumes the core presents table instructions on a one-cycle strobe
  interface in the mclk domain and honours cpu_stall; the flash array is
  driven through a simple row port (one word per cycle during program).
*/
// The register addresses and the AXI4-Lite interface to the registers were chosen for this implementation.
//
// Contract
// - rows of 32 words, 128 rows per panel
// - erase one row, program 32 words
// - 32 latches filled sequentially from zero; here each table write goes to the latch picked by EA bits 5:1
// - low table ops access bits 15:0
// - high table ops access bits 23:16
// - address is page byte joined with EA
// - latch table write completes in 2 cycles
// - low address captures EA 15:0
// - high address captures EA 23:16
// - software may write both address registers
// - write-only key; 0x55 then 0xAA unlocks
// - operation lasts 2 ms, processor stalled
// - start bit 15 launches, hardware clears
// - 0x4041 selects row erase with writes enabled
// - program sequence; start cleared at end
// - high write ignores source upper byte
// - software cannot clear start bit
// - reset during operation sets write error flag; here only wdt_reset sets it, rst_n clears it
// - done flag set on completion, software clears
module flash_self_program_ctrl #(
  parameter int OP_CYCLES = flash_prog_pkg::OP_CYCLES
) (
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic wdt_reset,
  // AXI4-Lite slave
  input wire logic [7:0] s_awaddr,
  input wire logic s_awvalid,
  output logic s_awready,
  input wire logic [31:0] s_wdata,
  input wire logic [3:0] s_wstrb,
  input wire logic s_wvalid,
  output logic s_wready,
  output logic [1:0] s_bresp,
  output logic s_bvalid,
  input wire logic s_bready,
  input wire logic [7:0] s_araddr,
  input wire logic s_arvalid,
  output logic s_arready,
  output logic [31:0] s_rdata,
  output logic [1:0] s_rresp,
  output logic s_rvalid,
  input wire logic s_rready,
  // table instruction port from the core
  input wire logic tbl_req,
  input wire logic tbl_write,
  input wire logic tbl_high,
  input wire logic tbl_byte,
  input wire logic [15:0] tbl_ea,
  input wire logic [15:0] tbl_wdata,
  output logic tbl_done,
  output logic [15:0] tbl_rdata,
  // flash array row port
  output logic [23:0] fl_addr,
  output logic fl_erase,
  output logic fl_prog,
  output logic [23:0] fl_wdata,
  input wire logic [23:0] fl_rdata,
  // core stall and completion flag
  output logic cpu_stall,
  output logic flash_done_irq_flag
);

  localparam int CW = $clog2(OP_CYCLES + 1);

  typedef struct packed {
    logic [15:0] control;
    logic [15:0] addr_low;
    logic [7:0] addr_high;
    logic [7:0] table_page;
    logic [1:0] key_step;
    logic done;
    logic [4:0] latch_idx;
    logic tbl_busy;
    logic tbl_done;
    logic [15:0] tbl_rdata;
    logic [CW-1:0] count;
    flash_prog_pkg::seq_state_t state;
    logic aw_held;
    logic [7:0] aw_addr;
    logic w_held;
    logic [31:0] w_data;
    logic [3:0] w_strb;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
  } state_t;

  state_t s_r;
  state_t s_nxt;
  logic [flash_prog_pkg::WORD_W-1:0] latch_r [flash_prog_pkg::ROW_WORDS];
  logic latch_we;
  logic [4:0] latch_wi;
  logic [23:0] latch_wd;

  function automatic logic is_reg(input logic [7:0] a);
    is_reg = a == flash_prog_pkg::OFF_CONTROL || a == flash_prog_pkg::OFF_ADDR_LOW ||
             a == flash_prog_pkg::OFF_ADDR_HIGH || a == flash_prog_pkg::OFF_UNLOCK_KEY ||
             a == flash_prog_pkg::OFF_TABLE_PAGE || a == flash_prog_pkg::OFF_STATUS;
  endfunction

  function automatic logic [15:0] merge16(input logic [15:0] old, input logic [31:0] d,
                                          input logic [3:0] st);
    merge16 = {st[1] ? d[15:8] : old[15:8], st[0] ? d[7:0] : old[7:0]};
  endfunction

  wire logic busy = s_r.state != flash_prog_pkg::ST_IDLE;

  ////////////////////////////////////////////////////////////////////////////
  always_comb begin
    logic wr_go;
    logic start_req;
    logic [15:0] newctl;
    logic [23:0] cur;
    wr_go = 1'b0;
    start_req = 1'b0;
    newctl = '0;
    cur = '0;
    s_nxt = s_r;
    latch_we = 1'b0;
    latch_wi = s_r.latch_idx;
    latch_wd = latch_r[s_r.latch_idx];
    s_nxt.tbl_done = 1'b0;

    // axi write: address and data taken independently, response after both
    if (s_awvalid && !s_r.aw_held) begin
      s_nxt.aw_held = 1'b1;
      s_nxt.aw_addr = s_awaddr;
    end
    if (s_wvalid && !s_r.w_held) begin
      s_nxt.w_held = 1'b1;
      s_nxt.w_data = s_wdata;
      s_nxt.w_strb = s_wstrb;
    end
    if (s_r.bvalid && s_bready) begin
      s_nxt.bvalid = 1'b0;
    end
    wr_go = s_r.aw_held && s_r.w_held && !s_r.bvalid;

    // any register write other than the second key breaks the unlock chain
    if (wr_go) begin
      s_nxt.aw_held = 1'b0;
      s_nxt.w_held = 1'b0;
      s_nxt.bvalid = 1'b1;
      s_nxt.bresp = is_reg(s_r.aw_addr) ? 2'b00 : 2'b10;
      s_nxt.key_step = 2'd0;
      case (s_r.aw_addr)
        flash_prog_pkg::OFF_CONTROL: begin
          newctl = merge16(s_r.control, s_r.w_data, s_r.w_strb);
          // start only with enable and a fresh key pair; software never clears it
          start_req = newctl[flash_prog_pkg::CTL_START_BIT] && !busy &&
                      newctl[flash_prog_pkg::CTL_WRITE_EN_BIT] && s_r.key_step == 2'd2;
          s_nxt.control = {start_req | s_r.control[15], newctl[14:0]};
          if (start_req) begin
            s_nxt.count = CW'(OP_CYCLES);
            s_nxt.state = (newctl[6:0] == flash_prog_pkg::OP_ROW_ERASE) ?
                          flash_prog_pkg::ST_ERASE : flash_prog_pkg::ST_PROGRAM;
            s_nxt.latch_idx = 5'd0;
          end
        end
        flash_prog_pkg::OFF_ADDR_LOW: begin
          if (!busy) s_nxt.addr_low = merge16(s_r.addr_low, s_r.w_data, s_r.w_strb);
        end
        flash_prog_pkg::OFF_ADDR_HIGH: begin
          if (!busy && s_r.w_strb[0]) s_nxt.addr_high = s_r.w_data[7:0];
        end
        flash_prog_pkg::OFF_UNLOCK_KEY: begin
          if (s_r.w_strb[0] && s_r.w_data[7:0] == flash_prog_pkg::KEY_FIRST) begin
            s_nxt.key_step = 2'd1;
          end else if (s_r.w_strb[0] && s_r.key_step == 2'd1 &&
                       s_r.w_data[7:0] == flash_prog_pkg::KEY_SECOND) begin
            s_nxt.key_step = 2'd2;
          end
        end
        flash_prog_pkg::OFF_TABLE_PAGE: begin
          if (s_r.w_strb[0]) s_nxt.table_page = s_r.w_data[7:0];
        end
        flash_prog_pkg::OFF_STATUS: begin
          if (s_r.w_strb[0] && s_r.w_data[flash_prog_pkg::STAT_DONE_BIT]) s_nxt.done = 1'b0;
        end
        default: begin
        end
      endcase
    end

    // axi read: one-cycle answer; key register reads as zero
    if (s_r.rvalid && s_rready) begin
      s_nxt.rvalid = 1'b0;
    end
    if (s_arvalid && !s_r.rvalid) begin
      s_nxt.rvalid = 1'b1;
      s_nxt.rresp = is_reg(s_araddr) ? 2'b00 : 2'b10;
      case (s_araddr)
        flash_prog_pkg::OFF_CONTROL: s_nxt.rdata = {16'h0000, s_r.control};
        flash_prog_pkg::OFF_ADDR_LOW: s_nxt.rdata = {16'h0000, s_r.addr_low};
        flash_prog_pkg::OFF_ADDR_HIGH: s_nxt.rdata = {24'h00_0000, s_r.addr_high};
        flash_prog_pkg::OFF_TABLE_PAGE: s_nxt.rdata = {24'h00_0000, s_r.table_page};
        flash_prog_pkg::OFF_STATUS: s_nxt.rdata = {30'h0000_0000, busy, s_r.done};
        default: s_nxt.rdata = 32'h0000_0000;
      endcase
    end

    // table instructions: two-cycle completion, address capture on each
    if (tbl_req && !busy && !s_r.tbl_busy) begin
      s_nxt.tbl_busy = 1'b1;
      s_nxt.addr_low = tbl_ea;
      s_nxt.addr_high = s_r.table_page;
      // latch index follows ea word offset, so each write lands at its own word of the row, in any order
      latch_wi = tbl_ea[5:1];
      cur = latch_r[tbl_ea[5:1]];
      if (tbl_write) begin
        latch_we = 1'b1;
        s_nxt.latch_idx = tbl_ea[5:1] + 5'd1;
        if (tbl_high) begin
          latch_wd = {tbl_wdata[7:0], cur[15:0]};
        end else if (tbl_byte) begin
          latch_wd = tbl_ea[0] ? {cur[23:16], tbl_wdata[7:0], cur[7:0]} :
                                 {cur[23:8], tbl_wdata[7:0]};
        end else begin
          latch_wd = {cur[23:16], tbl_wdata};
        end
      end else begin
        // reads come from the array at the 24-bit table address
        if (tbl_high) s_nxt.tbl_rdata = {8'h00, fl_rdata[23:16]};
        else if (tbl_byte) s_nxt.tbl_rdata = {8'h00, tbl_ea[0] ? fl_rdata[15:8] : fl_rdata[7:0]};
        else s_nxt.tbl_rdata = fl_rdata[15:0];
      end
    end else if (s_r.tbl_busy) begin
      s_nxt.tbl_busy = 1'b0;
      s_nxt.tbl_done = 1'b1;
    end

    // operation sequencer
    case (s_r.state)
      flash_prog_pkg::ST_IDLE: begin
      end
      flash_prog_pkg::ST_ERASE,
      flash_prog_pkg::ST_PROGRAM: begin
        s_nxt.count = s_r.count - CW'(1);
        if (s_r.state == flash_prog_pkg::ST_PROGRAM) s_nxt.latch_idx = s_r.latch_idx + 5'd1;
        if (s_r.count == CW'(1)) s_nxt.state = flash_prog_pkg::ST_FINISH;
      end
      flash_prog_pkg::ST_FINISH: begin
        s_nxt.control[flash_prog_pkg::CTL_START_BIT] = 1'b0;
        s_nxt.done = 1'b1;
        s_nxt.state = flash_prog_pkg::ST_IDLE;
      end
      default: s_nxt.state = flash_prog_pkg::ST_IDLE;
    endcase

    // watchdog reset mid-operation: abort, flag error, keep address
    if (wdt_reset) begin
      if (busy) s_nxt.control[flash_prog_pkg::CTL_WRITE_ERR_BIT] = 1'b1;
      s_nxt.control[flash_prog_pkg::CTL_START_BIT] = 1'b0;
      s_nxt.control[flash_prog_pkg::CTL_WRITE_EN_BIT] = 1'b0;
      s_nxt.state = flash_prog_pkg::ST_IDLE;
      s_nxt.key_step = 2'd0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // an external reset mid-operation is seen through a retained flag that the
  // core's reset generator must hold; here the async reset just clears state
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

  // latch array: no reset, contents undefined until loaded
  always_ff @(posedge mclk) begin
    if (latch_we) begin
      latch_r[latch_wi] <= latch_wd;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // row address forced to a row boundary: erase/program touch exactly one row
  assign fl_addr = (s_r.state == flash_prog_pkg::ST_IDLE) ?
                   {s_r.table_page, tbl_ea} :
                   {s_r.addr_high, s_r.addr_low[15:6], s_r.latch_idx, 1'b0};
  assign fl_erase = s_r.state == flash_prog_pkg::ST_ERASE &&
                    s_r.count == CW'(OP_CYCLES);
  assign fl_prog = s_r.state == flash_prog_pkg::ST_PROGRAM &&
                   s_r.count > CW'(OP_CYCLES - flash_prog_pkg::ROW_WORDS);
  assign fl_wdata = latch_r[s_r.latch_idx];
  assign cpu_stall = busy;
  assign tbl_done = s_r.tbl_done;
  assign tbl_rdata = s_r.tbl_rdata;
  assign flash_done_irq_flag = s_r.done;
  assign s_awready = !s_r.aw_held;
  assign s_wready = !s_r.w_held;
  assign s_bvalid = s_r.bvalid;
  assign s_bresp = s_r.bresp;
  assign s_arready = !s_r.rvalid;
  assign s_rvalid = s_r.rvalid;
  assign s_rdata = s_r.rdata;
  assign s_rresp = s_r.rresp;

endmodule

/* File: bench/flash_self_program_ctrl_monitor.sv */
/*
  checker for flash_self_program_ctrl: table timing, stall length, flash strobes.
  assumes it is bound to the design top and sees only its ports.
*/
module flash_self_program_ctrl_monitor #(
  parameter int OP_CYCLES = 40
) (
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic wdt_reset,
  input wire logic tbl_req,
  input wire logic [15:0] tbl_ea,
  input wire logic tbl_done,
  input wire logic [23:0] fl_addr,
  input wire logic fl_erase,
  input wire logic fl_prog,
  input wire logic cpu_stall,
  input wire logic flash_done_irq_flag,
  input wire logic s_bvalid
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [31:0] sc_r;
  logic [5:0] pc_r;
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      sc_r <= '0;
      pc_r <= '0;
    end else begin
      sc_r <= cpu_stall ? sc_r + 32'h1 : '0;
      pc_r <= fl_prog ? pc_r + 6'h1 : '0;
    end
  end
  ////////////////////////////////////////////////////////////
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_n);
  a_done_two_late: assert property (tbl_done |-> $past(tbl_req, 2))
    else $error("table done without request");
  a_req_gets_done: assert property (tbl_req && !cpu_stall && !$past(tbl_req) |-> ##2 tbl_done)
    else $error("table request not answered");
  a_addr_joins_ea: assert property (tbl_req && !cpu_stall |-> fl_addr[15:0] == tbl_ea)
    else $error("array address differs from ea");
  // a watchdog abort ends the stall early, so it is left out
  a_stall_length: assert property ($fell(cpu_stall) && !$past(wdt_reset) |->
    sc_r >= OP_CYCLES && sc_r <= OP_CYCLES + 2)
    else $error("stall length wrong");
  a_done_at_end: assert property ($fell(cpu_stall) && !$past(wdt_reset) |->
    ##[0:1] flash_done_irq_flag)
    else $error("done flag missing at end");
  a_done_sticky: assert property (flash_done_irq_flag |=> flash_done_irq_flag || $rose(s_bvalid))
    else $error("done flag dropped");
  a_erase_pulse: assert property (fl_erase |=> !fl_erase && cpu_stall)
    else $error("erase strobe wrong");
  a_prog_words: assert property ($fell(fl_prog) && !$past(wdt_reset) |-> pc_r == 6'h20)
    else $error("program burst not 32 words");
  a_prog_stalls: assert property (fl_prog |-> cpu_stall)
    else $error("program without stall");
  a_stall_no_done: assert property (cpu_stall && $past(cpu_stall) && $past(cpu_stall, 2) |-> !tbl_done)
    else $error("table op done while stalled");
  c_erase: cover property (fl_erase);
  c_program: cover property ($fell(fl_prog));
  c_done: cover property ($rose(flash_done_irq_flag));
endmodule
bind flash_self_program_ctrl flash_self_program_ctrl_monitor #(.OP_CYCLES(OP_CYCLES)) mon_inst (
  .mclk(mclk), .rst_n(rst_n), .wdt_reset(wdt_reset), .tbl_req(tbl_req), .tbl_ea(tbl_ea),
  .tbl_done(tbl_done), .fl_addr(fl_addr), .fl_erase(fl_erase), .fl_prog(fl_prog),
  .cpu_stall(cpu_stall), .flash_done_irq_flag(flash_done_irq_flag), .s_bvalid(s_bvalid));

/* File: bench/core_model.sv */
/*
  model of the core issuing table instructions, plus a small flash array.
  assumes one table op at a time, issued only while the core is not stalled.
*/
module core_model (
  input wire logic mclk,
  input wire logic cpu_stall,
  input wire logic tbl_done,
  input wire logic [15:0] tbl_rdata,
  input wire logic [23:0] fl_addr,
  input wire logic fl_erase,
  input wire logic fl_prog,
  input wire logic [23:0] fl_wdata,
  output logic tbl_req,
  output logic tbl_write,
  output logic tbl_high,
  output logic tbl_byte,
  output logic [15:0] tbl_ea,
  output logic [15:0] tbl_wdata,
  output logic [23:0] fl_rdata
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [23:0] mem [4096];
  initial begin
    {tbl_req, tbl_write, tbl_high, tbl_byte, tbl_ea, tbl_wdata} = '0;
    for (int i = 0; i < 4096; i++) mem[i] = 24'h12_3456;
  end
  always_comb fl_rdata = mem[fl_addr[12:1]];
  // array is folded to 4k words, enough for the single row under test
  always @(posedge mclk) begin
    if (fl_erase) for (int k = 0; k < 32; k++) mem[{fl_addr[12:6], 5'(k)}] <= 24'hff_ffff;
    if (fl_prog) mem[fl_addr[12:1]] <= fl_wdata;
  end
  task automatic op(input logic w, h, b, input logic [15:0] ea, d, output logic dn,
                    output logic [15:0] rd);
    @(posedge mclk);
    while (cpu_stall) @(posedge mclk);
    {tbl_req, tbl_write, tbl_high, tbl_byte, tbl_ea, tbl_wdata} <= {1'b1, w, h, b, ea, d};
    @(posedge mclk);
    tbl_req <= 1'b0;
    repeat (2) @(posedge mclk);
    dn = tbl_done;
    rd = tbl_rdata;
  endtask
endmodule

/* File: bench/flash_self_program_ctrl_bench.sv */
/*
  bench for flash_self_program_ctrl: registers, row load, program, erase,
  refused starts and watchdog abort. assumes core_model on the core side.
*/
module flash_self_program_ctrl_bench;
  timeunit 1ns;
  timeprecision 1ps;
  logic mclk, rst_n, wdt_reset, s_awvalid, s_wvalid, s_bready, s_arvalid, s_rready, dn;
  logic s_awready, s_wready, s_bvalid, s_arready, s_rvalid, tbl_req, tbl_write, tbl_high;
  logic tbl_byte, tbl_done, fl_erase, fl_prog, cpu_stall, flash_done_irq_flag;
  logic [7:0] s_awaddr, s_araddr, page;
  logic [31:0] s_wdata, s_rdata, rv, seed;
  logic [3:0] s_wstrb;
  logic [1:0] s_bresp, s_rresp, rsp, bsp;
  logic [15:0] tbl_ea, tbl_wdata, tbl_rdata, base, rd16;
  logic [23:0] fl_addr, fl_wdata, fl_rdata, img [32];
  int n_fail, num_checks, cyc;
  flash_self_program_ctrl #(.OP_CYCLES(40)) flash_self_program_ctrl_inst (
    .mclk(mclk), .rst_n(rst_n), .wdt_reset(wdt_reset), .s_awaddr(s_awaddr),
    .s_awvalid(s_awvalid), .s_awready(s_awready), .s_wdata(s_wdata), .s_wstrb(s_wstrb),
    .s_wvalid(s_wvalid), .s_wready(s_wready), .s_bresp(s_bresp), .s_bvalid(s_bvalid),
    .s_bready(s_bready), .s_araddr(s_araddr), .s_arvalid(s_arvalid), .s_arready(s_arready),
    .s_rdata(s_rdata), .s_rresp(s_rresp), .s_rvalid(s_rvalid), .s_rready(s_rready),
    .tbl_req(tbl_req), .tbl_write(tbl_write), .tbl_high(tbl_high), .tbl_byte(tbl_byte),
    .tbl_ea(tbl_ea), .tbl_wdata(tbl_wdata), .tbl_done(tbl_done), .tbl_rdata(tbl_rdata),
    .fl_addr(fl_addr), .fl_erase(fl_erase), .fl_prog(fl_prog), .fl_wdata(fl_wdata),
    .fl_rdata(fl_rdata), .cpu_stall(cpu_stall), .flash_done_irq_flag(flash_done_irq_flag));
  core_model core_model_inst (
    .mclk(mclk), .cpu_stall(cpu_stall), .tbl_done(tbl_done), .tbl_rdata(tbl_rdata),
    .fl_addr(fl_addr), .fl_erase(fl_erase), .fl_prog(fl_prog), .fl_wdata(fl_wdata),
    .tbl_req(tbl_req), .tbl_write(tbl_write), .tbl_high(tbl_high), .tbl_byte(tbl_byte),
    .tbl_ea(tbl_ea), .tbl_wdata(tbl_wdata), .fl_rdata(fl_rdata));
  ////////////////////////////////////////////////////////////
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  function automatic logic [23:0] word(input logic [15:0] lo, hi);
    return {hi[7:0], lo};
  endfunction
  task automatic chk(input logic [31:0] seen, exp);
    num_checks++;
    if (seen !== exp) begin
      n_fail++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic results;
    $display("checks %0d mismatches %0d", num_checks, n_fail);
    if (n_fail == 0 && num_checks > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic ad, wd;
    {ad, wd} = 2'h0;
    @(posedge mclk);
    {s_awaddr, s_wdata, s_awvalid, s_wvalid, s_bready} <= {a, d, 3'h7};
    do begin
      @(posedge mclk);
      ad |= s_awready;
      wd |= s_wready;
      if (ad) s_awvalid <= 1'b0;
      if (wd) s_wvalid <= 1'b0;
    end while (!s_bvalid);
    bsp = s_bresp;
    s_bready <= 1'b0;
  endtask
  task automatic rc(input logic [7:0] a, input logic [31:0] e);
    @(posedge mclk);
    {s_araddr, s_arvalid, s_rready} <= {a, 2'h3};
    do begin
      @(posedge mclk);
      if (s_arready) s_arvalid <= 1'b0;
    end while (!s_rvalid);
    {rv, rsp} = {s_rdata, s_rresp};
    s_rready <= 1'b0;
    if (a != flash_prog_pkg::OFF_STATUS || e != 32'h0000_ffff) chk(rv, e);
  endtask
  task automatic start(input logic [15:0] c);
    wr(flash_prog_pkg::OFF_UNLOCK_KEY, {24'h0, flash_prog_pkg::KEY_FIRST});
    wr(flash_prog_pkg::OFF_UNLOCK_KEY, {24'h0, flash_prog_pkg::KEY_SECOND});
    wr(flash_prog_pkg::OFF_CONTROL, {16'h0, c});
    repeat (2) @(posedge mclk);
  endtask
  // polls status without comparing, then checks the last value and the done flag itself
  task automatic wait_done;
    rv = '0;
    repeat (40) if (rv[0] !== 1'b1) rc(flash_prog_pkg::OFF_STATUS, 32'h0000_ffff);
    chk(rv, 32'h0000_0001);
    chk(32'(flash_done_irq_flag), 32'h0000_0001);
  endtask
  task automatic row(input logic er);
    logic [15:0] lo;
    for (int k = 0; k < 32; k++) begin
      core_model_inst.op(1'b0, 1'b0, 1'b0, base + 16'(2 * k), 16'h0, dn, lo);
      core_model_inst.op(1'b0, 1'b1, 1'b0, base + 16'(2 * k), 16'h0, dn, rd16);
      chk({8'h0, rd16[7:0], lo}, {8'h0, er ? 24'hff_ffff : img[k]});
    end
  endtask
  always #10 mclk = ~mclk;
  always @(posedge mclk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      n_fail++;
      results;
    end
  end
  initial begin
    {mclk, rst_n, wdt_reset, s_awvalid, s_wvalid, s_bready, s_arvalid, s_rready} = 8'h0;
    {s_awaddr, s_araddr, s_wdata, s_wstrb, seed} = {48'h0, 4'hf, 32'h0000_03ed};
    repeat (5) @(posedge mclk);
    rst_n <= 1'b1;
    rc(flash_prog_pkg::OFF_CONTROL, 32'h0);
    rc(8'h1c, 32'h0);
    chk(32'(rsp), 32'h0000_0002);
    wr(8'h1c, 32'h0);
    chk(32'(bsp), 32'h0000_0002);
    wr(flash_prog_pkg::OFF_UNLOCK_KEY, 32'h0000_0055);
    rc(flash_prog_pkg::OFF_UNLOCK_KEY, 32'h0);
    seed = lfsr(seed);
    wr(flash_prog_pkg::OFF_ADDR_LOW, seed);
    chk(32'(bsp), 32'h0000_0000);
    rc(flash_prog_pkg::OFF_ADDR_LOW, {16'h0, seed[15:0]});
    wr(flash_prog_pkg::OFF_ADDR_HIGH, seed);
    rc(flash_prog_pkg::OFF_ADDR_HIGH, {24'h0, seed[7:0]});
    $display("test registers done");
    {page, base} = {seed[23:16], seed[31:22], 6'h0};
    wr(flash_prog_pkg::OFF_TABLE_PAGE, {24'h0, page});
    for (int k = 0; k < 32; k++) begin
      seed = lfsr(seed);
      core_model_inst.op(1'b1, 1'b0, 1'b0, base + 16'(2 * k), seed[15:0], dn, rd16);
      chk(32'(dn), 32'h0000_0001);
      core_model_inst.op(1'b1, 1'b1, 1'b0, base + 16'(2 * k), seed[31:16], dn, rd16);
      chk(32'(dn), 32'h0000_0001);
      img[k] = word(seed[15:0], seed[31:16]);
      // corner: odd-address byte write replaces only bits 15:8 of word 5
      if (k == 5) begin
        core_model_inst.op(1'b1, 1'b0, 1'b1, base + 16'h000b, 16'h00a5, dn, rd16);
        chk(32'(dn), 32'h0000_0001);
        img[k][15:8] = 8'ha5;
      end
    end
    rc(flash_prog_pkg::OFF_ADDR_LOW, {16'h0, base + 16'h003e});
    rc(flash_prog_pkg::OFF_ADDR_HIGH, {24'h0, page});
    $display("test latch load done");
    wr(flash_prog_pkg::OFF_CONTROL, 32'h0000_c001);
    rc(flash_prog_pkg::OFF_CONTROL, 32'h0000_4001);
    start(16'h8001);
    rc(flash_prog_pkg::OFF_CONTROL, 32'h0000_0001);
    $display("test refused start done");
    start(16'hc001);
    rc(flash_prog_pkg::OFF_CONTROL, 32'h0000_c001);
    wr(flash_prog_pkg::OFF_CONTROL, 32'h0000_4001);
    rc(flash_prog_pkg::OFF_CONTROL, 32'h0000_c001);
    wait_done;
    rc(flash_prog_pkg::OFF_CONTROL, 32'h0000_4001);
    row(1'b0);
    core_model_inst.op(1'b0, 1'b0, 1'b1, base + 16'h000b, 16'h0, dn, rd16);
    chk(32'(rd16), 32'h0000_00a5);
    wr(flash_prog_pkg::OFF_STATUS, 32'h0000_0001);
    rc(flash_prog_pkg::OFF_STATUS, 32'h0);
    chk(32'(flash_done_irq_flag), 32'h0000_0000);
    $display("test program done");
    wr(flash_prog_pkg::OFF_CONTROL, 32'h0000_4041);
    rc(flash_prog_pkg::OFF_CONTROL, 32'h0000_4041);
    // a table read elsewhere moves the captured row; the software write must win
    core_model_inst.op(1'b0, 1'b0, 1'b0, base ^ 16'h0040, 16'h0, dn, rd16);
    chk(32'(dn), 32'h0000_0001);
    wr(flash_prog_pkg::OFF_ADDR_LOW, {16'h0, base + 16'h0020});
    start(16'hc041);
    wait_done;
    row(1'b1);
    $display("test erase done");
    start(16'hc001);
    while (cpu_stall !== 1'b1) @(posedge mclk);
    wdt_reset <= 1'b1;
    @(posedge mclk);
    wdt_reset <= 1'b0;
    rc(flash_prog_pkg::OFF_CONTROL, 32'h0000_2001);
    rc(flash_prog_pkg::OFF_ADDR_LOW, {16'h0, base + 16'h003e});
    $display("test watchdog abort done");
    results;
  end
endmodule
